// file: hw/ufac_pkg.sv
`default_nettype none
package ufac_pkg;
  localparam logic [7:0]  FCTL_ADDR      = 8'hd1;
  localparam logic [7:0]  FCTL_RESET     = 8'h00;
  localparam int          FCTL_KEY_LSB   = 4;
  localparam int          FCTL_MAP_BIT   = 3;
  localparam int          FCTL_MODE_LSB  = 1;
  localparam int          FCTL_BUSY_BIT  = 0;
  localparam logic [3:0]  KEY_ARM        = 4'h5;
  localparam logic [3:0]  KEY_FIRE       = 4'ha;
  localparam logic [7:0]  CFG_ERASED     = 8'hff;
  localparam int          CFG_SPEED_BIT  = 7;
  localparam int          CFG_JUMP_BIT   = 6;
  localparam int          CFG_LOCK_MSB   = 2;
  localparam logic [2:0]  LOCK_OPEN      = 3'h7;
  localparam logic [15:0] VEC_USER       = 16'h0000;
  localparam logic [15:0] VEC_BOOT       = 16'hf800;
  localparam logic [15:0] EXTRA_ROW_BASE      = 16'hff80;
  localparam logic [15:0] CFG_CODE_ADDR  = 16'h0000;
  localparam logic [7:0]  READ_BLANK     = 8'hff;
  localparam int          PAGE_BYTES     = 128;
  localparam int          PAGE_AW        = 7;
  localparam logic [6:0]  CFG_BUF_INDEX  = 7'h00;
  localparam int          CLK_PER_MC_X1  = 12;
  localparam int          CLK_PER_MC_X2  = 6;

  typedef enum logic [1:0] {
    MODE_USER,
    MODE_EXTRA_ROW,
    MODE_CFG,
    MODE_BUF_RESET
  } ufac_mode_t;

  typedef enum logic [1:0] {
    REGION_USER,
    REGION_BOOT,
    REGION_EXT,
    REGION_NONE
  } ufac_region_t;
endpackage : ufac_pkg
`default_nettype wire

// file: hw/ufac_page_buffer.sv
`default_nettype none
module ufac_page_buffer (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       wr_en,
  input  wire logic [ufac_pkg::PAGE_AW-1:0] wr_addr,
  input  wire logic [7:0]                 wr_data,
  input  wire logic                       clr,
  input  wire logic [ufac_pkg::PAGE_AW-1:0] rd_addr,
  output logic      [7:0]                 rd_data_q,
  output logic                            rd_written_q
);
  import ufac_pkg::*;

  // Cells carry no reset; the written mask tells the array which bytes to commit.
  logic [7:0]            mem [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] written_q;

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // A load in the clearing cycle survives the clear, so a late clear never drops a fresh byte.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      written_q <= '0;
    end else begin
      if (clr) begin
        written_q <= '0;
      end
      if (wr_en) begin
        written_q[wr_addr] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data_q    <= 8'h00;
      rd_written_q <= 1'b0;
    end else begin
      rd_data_q    <= mem[rd_addr];
      rd_written_q <= written_q[rd_addr];
    end
  end
endmodule : ufac_page_buffer
`default_nettype wire

// file: hw/ufac_launch_key.sv
`default_nettype none
module ufac_launch_key (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       wr_en,
  input  wire logic [3:0] key,
  output logic            fire
);
  import ufac_pkg::*;

  logic armed_q;

  // Any write to the control register re-evaluates the arm state, so a stray value breaks the pair.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      armed_q <= 1'b0;
    end else if (wr_en) begin
      armed_q <= (key == KEY_ARM);
    end
  end

  assign fire = wr_en && armed_q && (key == KEY_FIRE);
endmodule : ufac_launch_key
`default_nettype wire

// file: hw/ufac_ctrl.sv
`default_nettype none
//Contract
// RQ1: Programmed clock-speed bit gives double speed, six clocks per cycle, after reset.
// RQ2: Unprogrammed clock-speed bit gives standard single speed after reset.
// RQ3: Unprogrammed boot-jump bit: boot map cleared, start at 0000h at reset.
// RQ4: Programmed boot-jump bit: boot map set, start at F800h at reset.
// RQ5: Three lock bits are changed only by the external programmer.
// RQ6: One 128-byte page buffer belongs to the user flash block.
// RQ7: Page buffer stages data for user array, extra row and config byte.
// RQ8: Page buffer is write-only to software.
// RQ9: User flash programming works only from boot flash; otherwise no effect.
// RQ10: Boot flash is never programmed by software.
// RQ11: User code reads user flash, loads buffer; boot code also programs, reads boot.
// RQ12: External code never loads or programs; user reads follow lock bits.
// RQ13: Launch needs key 5 then key A; mode field picks operation.
// RQ14: Map bit set routes data writes into page buffer.
// RQ15: Map bit clear lets data writes reach external data memory.
// RQ16: Control registers map buffer, config byte and extra row into spaces.
// RQ17: Control register resets to all zeros.
// RQ18: Mode field selects code read view: user, extra row, config, buffer reset.
// RQ19: Write address bits 6:0 pick byte, 15:7 pick page.
// RQ20: Map bit overrides the external RAM select.
// RQ21: Software changes only upper config nibble; lower nibble by parallel hardware.
// RQ22: Busy bit reads 1 during programming, hardware clears it, writes ignored.
// RQ23: Software polls busy before reloading buffer or launching again.
module ufac_ctrl (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  por_n,
  input  wire ufac_pkg::ufac_region_t exec_region,
  input  wire logic                  sfr_wr_en,
  input  wire logic                  sfr_rd_en,
  input  wire logic [7:0]            sfr_addr,
  input  wire logic [7:0]            sfr_wdata,
  output logic      [7:0]            sfr_rdata_q,
  input  wire logic                  xdata_wr_en,
  input  wire logic [15:0]           xdata_addr,
  input  wire logic [7:0]            xdata_wdata,
  input  wire logic                  external_ram_select,
  output logic                       xram_wr_en,
  output logic                       eram_wr_en,
  input  wire logic                  code_rd_en,
  input  wire logic [15:0]           code_addr,
  output logic      [7:0]            code_rdata_q,
  output logic                       code_rd_valid_q,
  output logic                       code_rd_blocked_q,
  output logic                       arr_rd_en,
  output logic                       arr_rd_extra_row,
  output logic      [15:0]           arr_rd_addr,
  input  wire logic [7:0]            arr_rd_data,
  output logic                       arr_prog_req_q,
  output logic                       arr_prog_extra_row_q,
  output logic      [8:0]            arr_prog_page_q,
  input  wire logic [6:0]            arr_buf_addr,
  output logic      [7:0]            arr_buf_data_q,
  output logic                       arr_buf_written_q,
  input  wire logic                  arr_done,
  input  wire logic                  par_cfg_wr_en,
  input  wire logic [7:0]            par_cfg_wdata,
  output logic                       double_speed_select_q,
  output logic      [3:0]            clocks_per_cycle_q,
  output logic                       boot_region_map_q,
  output logic      [15:0]           reset_vector_q,
  output logic      [2:0]            general_lock_bits
);
  import ufac_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PROG,
    ST_CFG_RD,
    ST_CFG_WR
  } ufac_state_t;

  ufac_state_t state_q;
  logic [3:0]  key_q;
  logic        map_bit_q;
  ufac_mode_t  mode_q;
  logic        busy_q;
  logic [7:0]  cfg_q;
  logic [8:0]  page_q;
  logic        fctl_wr;
  logic        fire;
  logic        launch_ok;
  logic        buf_load;
  logic        buf_clr;
  logic [6:0]  buf_rd_addr;
  logic [7:0]  buf_rd_data;
  logic        buf_rd_written;
  logic        boot_read;
  logic        read_blocked;
  logic [7:0]  code_data_d;

  assign fctl_wr           = sfr_wr_en && (sfr_addr == FCTL_ADDR);
  assign general_lock_bits = cfg_q[CFG_LOCK_MSB:0];

  ufac_launch_key u_key (
    .clk   (clk),
    .rst_n (rst_n),
    .wr_en (fctl_wr),
    .key   (sfr_wdata[FCTL_KEY_LSB +: 4]),
    .fire  (fire)
  );

  // A fired key pair from any region but boot flash, or while busy, is swallowed.
  assign launch_ok = fire && (exec_region == REGION_BOOT) && !busy_q; // RQ9 RQ13

  // Field writes land every time; the busy bit is owned by hardware.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      key_q     <= FCTL_RESET[7:4]; // RQ17
      map_bit_q <= FCTL_RESET[FCTL_MAP_BIT]; // RQ17
      mode_q    <= MODE_USER; // RQ17
    end else if (fctl_wr) begin
      key_q     <= sfr_wdata[FCTL_KEY_LSB +: 4];
      map_bit_q <= sfr_wdata[FCTL_MAP_BIT];
      mode_q    <= ufac_mode_t'(sfr_wdata[FCTL_MODE_LSB +: 2]);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sfr_rdata_q <= 8'h00;
    end else if (sfr_rd_en && sfr_addr == FCTL_ADDR) begin
      sfr_rdata_q <= {key_q, map_bit_q, mode_q, busy_q}; // RQ22
    end else begin
      sfr_rdata_q <= 8'h00;
    end
  end

  // Data writes: the map bit wins over the external RAM select.
  assign buf_load   = xdata_wr_en && map_bit_q && (exec_region == REGION_USER ||
                      exec_region == REGION_BOOT); // RQ11 RQ12 RQ14 RQ20
  assign xram_wr_en = xdata_wr_en && !map_bit_q && external_ram_select; // RQ15 RQ20
  assign eram_wr_en = xdata_wr_en && !map_bit_q && !external_ram_select; // RQ15

  // The page latched is the one of the last loaded byte.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      page_q <= 9'h000;
    end else if (buf_load) begin
      page_q <= xdata_addr[15:7]; // RQ19
    end
  end

  // Programming modes clear at launch; the config commit still needs byte 0, so it clears after reading it.
  assign buf_clr     = (launch_ok && mode_q != MODE_CFG) || state_q == ST_CFG_WR; // RQ7 RQ13 RQ18
  assign buf_rd_addr = (state_q == ST_CFG_RD) ? CFG_BUF_INDEX : arr_buf_addr;

  // Only the config commit reads this buffer, the array reads the snapshot; no software path exists.
  ufac_page_buffer u_buf (
    .clk          (clk),
    .rst_n        (rst_n),
    .wr_en        (buf_load),
    .wr_addr      (xdata_addr[6:0]),
    .wr_data      (xdata_wdata),
    .clr          (buf_clr),
    .rd_addr      (buf_rd_addr),
    .rd_data_q    (buf_rd_data),
    .rd_written_q (buf_rd_written)
  ); // RQ6 RQ7 RQ8 RQ19

  // The buffer is cleared at the same edge the array is asked to program, so the array
  // must take its bytes from a copy made before; a committed snapshot is held here.
  // Loads that arrive while busy are kept out of it, so the page in flight never changes.
  logic snap_load;
  logic snap_clr;

  assign snap_load = buf_load && state_q == ST_IDLE;
  assign snap_clr  = (state_q == ST_PROG && arr_done) ||
                     (launch_ok && (mode_q == MODE_BUF_RESET || mode_q == MODE_CFG));

  ufac_page_buffer u_snap (
    .clk          (clk),
    .rst_n        (rst_n),
    .wr_en        (snap_load),
    .wr_addr      (xdata_addr[6:0]),
    .wr_data      (xdata_wdata),
    .clr          (snap_clr),
    .rd_addr      (arr_buf_addr),
    .rd_data_q    (arr_buf_data_q),
    .rd_written_q (arr_buf_written_q)
  ); // RQ7

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (launch_ok && (mode_q == MODE_USER || mode_q == MODE_EXTRA_ROW)) begin
            state_q <= ST_PROG;
          end else if (launch_ok && mode_q == MODE_CFG) begin
            state_q <= ST_CFG_RD;
          end
        end
        ST_PROG: begin
          if (arr_done) begin
            state_q <= ST_IDLE;
          end
        end
        ST_CFG_RD: state_q <= ST_CFG_WR;
        ST_CFG_WR: state_q <= ST_IDLE;
        default:   state_q <= ST_IDLE;
      endcase
    end
  end

  // Busy covers the programming wait; a buffer reset completes within the launch cycle.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_q <= FCTL_RESET[FCTL_BUSY_BIT]; // RQ17
    end else if (launch_ok && mode_q != MODE_BUF_RESET) begin
      busy_q <= 1'b1; // RQ22
    end else if ((state_q == ST_PROG && arr_done) || state_q == ST_CFG_WR) begin
      busy_q <= 1'b0; // RQ22
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      arr_prog_req_q  <= 1'b0;
      arr_prog_extra_row_q <= 1'b0;
      arr_prog_page_q <= 9'h000;
    end else if (launch_ok && (mode_q == MODE_USER || mode_q == MODE_EXTRA_ROW)) begin
      arr_prog_req_q  <= 1'b1; // RQ9 RQ10
      arr_prog_extra_row_q <= (mode_q == MODE_EXTRA_ROW);
      arr_prog_page_q <= page_q; // RQ19
    end else if (arr_done) begin
      arr_prog_req_q  <= 1'b0;
    end
  end

  // Nonvolatile byte: survives core resets, erased only at power-on.
  always_ff @(posedge clk) begin
    if (!por_n) begin
      cfg_q <= CFG_ERASED;
    end else if (par_cfg_wr_en) begin
      cfg_q <= par_cfg_wdata; // RQ5 RQ21
    end else if (state_q == ST_CFG_WR && buf_rd_written) begin
      cfg_q <= {buf_rd_data[7:4], cfg_q[3:0]}; // RQ5 RQ21
    end
  end

  // Sampled throughout reset so the level at release is what the core sees.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      double_speed_select_q <= !cfg_q[CFG_SPEED_BIT]; // RQ1 RQ2
      clocks_per_cycle_q    <= cfg_q[CFG_SPEED_BIT] ? 4'(CLK_PER_MC_X1) : 4'(CLK_PER_MC_X2); // RQ1 RQ2
      boot_region_map_q     <= !cfg_q[CFG_JUMP_BIT]; // RQ3 RQ4
      reset_vector_q        <= cfg_q[CFG_JUMP_BIT] ? VEC_USER : VEC_BOOT; // RQ3 RQ4
    end
  end

  // Boot flash is visible only while mapped, and only to boot code while the mode field selects user mode.
  assign boot_read    = boot_region_map_q && (code_addr >= VEC_BOOT) && mode_q == MODE_USER;
  assign read_blocked = (boot_read && exec_region != REGION_BOOT) ||
                        (exec_region == REGION_EXT && general_lock_bits != LOCK_OPEN); // RQ11 RQ12

  assign arr_rd_en   = code_rd_en && !read_blocked && mode_q != MODE_CFG;
  assign arr_rd_extra_row = (mode_q == MODE_EXTRA_ROW); // RQ16 RQ18
  assign arr_rd_addr = code_addr;

  always_comb begin
    code_data_d = READ_BLANK;
    case (mode_q)
      MODE_USER, MODE_BUF_RESET: code_data_d = arr_rd_data; // RQ18
      MODE_EXTRA_ROW: code_data_d = (code_addr >= EXTRA_ROW_BASE) ? arr_rd_data : READ_BLANK; // RQ18
      MODE_CFG:  code_data_d = (code_addr == CFG_CODE_ADDR) ? cfg_q : READ_BLANK; // RQ16 RQ18
      default:   code_data_d = READ_BLANK;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      code_rdata_q      <= 8'h00;
      code_rd_valid_q   <= 1'b0;
      code_rd_blocked_q <= 1'b0;
    end else begin
      code_rd_valid_q   <= code_rd_en;
      code_rd_blocked_q <= code_rd_en && read_blocked;
      if (code_rd_en) begin
        code_rdata_q <= read_blocked ? READ_BLANK : code_data_d;
      end
    end
  end

  chk_busy_on_launch: assert property (@(posedge clk) disable iff (!rst_n) // RQ22
    launch_ok && mode_q != MODE_BUF_RESET |=> busy_q)
    else $error("busy did not rise after launch");

  chk_no_prog_outside: assert property (@(posedge clk) disable iff (!rst_n) // RQ9
    $rose(arr_prog_req_q) |-> $past(exec_region) == REGION_BOOT)
    else $error("programming started outside boot flash");

  chk_key_pair: assert property (@(posedge clk) disable iff (!rst_n) // RQ13
    $rose(busy_q) |-> $past(fctl_wr) && $past(sfr_wdata[7:4]) == KEY_FIRE && $past(key_q) == KEY_ARM)
    else $error("launch without 5 then A");

  chk_map_route: assert property (@(posedge clk) disable iff (!rst_n) // RQ14
    xdata_wr_en && map_bit_q |-> !xram_wr_en && !eram_wr_en)
    else $error("mapped write leaked to data memory");

  chk_ext_no_load: assert property (@(posedge clk) disable iff (!rst_n) // RQ12
    exec_region == REGION_EXT |-> !buf_load)
    else $error("external code loaded the buffer");

  chk_busy_clears: assert property (@(posedge clk) disable iff (!rst_n) // RQ22
    state_q == ST_PROG && arr_done |=> !busy_q && state_q == ST_IDLE)
    else $error("busy not cleared on completion");

  chk_reset_zero: assert property (@(posedge clk) // RQ17
    !rst_n |=> {key_q, map_bit_q, mode_q, busy_q} == FCTL_RESET)
    else $error("control register not zero after reset");

  chk_cfg_low_kept: assert property (@(posedge clk) disable iff (!rst_n) // RQ21
    !par_cfg_wr_en && por_n |=> cfg_q[3:0] == $past(cfg_q[3:0]))
    else $error("lower config nibble changed by software");

  chk_vector_pick: assert property (@(posedge clk) // RQ3 RQ4
    !rst_n ##1 rst_n |-> reset_vector_q == ($past(cfg_q[CFG_JUMP_BIT]) ? VEC_USER : VEC_BOOT) &&
      boot_region_map_q == !$past(cfg_q[CFG_JUMP_BIT]))
    else $error("reset vector does not match boot jump bit");

  chk_speed_pick: assert property (@(posedge clk) // RQ1 RQ2
    !rst_n ##1 rst_n |-> double_speed_select_q == !$past(cfg_q[CFG_SPEED_BIT]) &&
      clocks_per_cycle_q == ($past(cfg_q[CFG_SPEED_BIT]) ? 4'(CLK_PER_MC_X1) : 4'(CLK_PER_MC_X2)))
    else $error("clock speed does not match config byte");

  chk_cfg_commit: assert property (@(posedge clk) disable iff (!rst_n) // RQ7 RQ21
    state_q == ST_CFG_WR && buf_rd_written && !par_cfg_wr_en && por_n |=> cfg_q[7:4] == $past(buf_rd_data[7:4]))
    else $error("config byte commit lost");

  chk_buf_reset_quiet: assert property (@(posedge clk) disable iff (!rst_n) // RQ18
    launch_ok && mode_q == MODE_BUF_RESET |=> !busy_q && state_q == ST_IDLE && !arr_prog_req_q)
    else $error("buffer reset started an operation");

  chk_blocked_blank: assert property (@(posedge clk) disable iff (!rst_n) // RQ11 RQ12
    code_rd_en && read_blocked |=> code_rd_blocked_q && code_rdata_q == READ_BLANK)
    else $error("blocked read returned data");

  chk_busy_sw_proof: assert property (@(posedge clk) disable iff (!rst_n) // RQ22
    fctl_wr && !launch_ok && !busy_q |=> !busy_q)
    else $error("software write changed the busy bit");

  chk_unmapped_route: assert property (@(posedge clk) disable iff (!rst_n) // RQ15 RQ20
    xdata_wr_en && !map_bit_q |-> !buf_load && xram_wr_en == external_ram_select &&
      eram_wr_en == !external_ram_select)
    else $error("unmapped write misrouted");
endmodule : ufac_ctrl
`default_nettype wire

// file: verif/ufac_array_model.sv
`default_nettype none
module ufac_array_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        slow,
  input  wire logic        arr_rd_en,
  input  wire logic        arr_rd_extra_row,
  input  wire logic [15:0] arr_rd_addr,
  output logic      [7:0]  arr_rd_data,
  input  wire logic        arr_prog_req_q,
  output logic      [6:0]  arr_buf_addr,
  output logic             arr_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] cnt_q;
  logic [7:0] pat;
  assign pat = arr_rd_addr[7:0] ^ arr_rd_addr[15:8] ^ (arr_rd_extra_row ? 8'h5a : 8'h00);
  // An idle read bus shows the inverse, so a stale byte never passes for a fresh one.
  assign arr_rd_data = arr_rd_en ? pat : ~pat;
  // The first 4 staged bytes, or 21 when slow, are walked during programming, one byte a cycle.
  assign arr_buf_addr = cnt_q;
  assign arr_done = arr_prog_req_q && (cnt_q == (slow ? 7'h14 : 7'h03));
  always_ff @(posedge clk) begin
    if (!rst_n || !arr_prog_req_q || arr_done) begin
      cnt_q <= 7'h00;
    end else begin
      cnt_q <= cnt_q + 7'h01;
    end
  end
endmodule : ufac_array_model
`default_nettype wire

// file: verif/tb.sv
`default_nettype none
module tb;
  import ufac_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk, rst_n, por_n, slow, sfr_wr_en, sfr_rd_en, xdata_wr_en;
  logic         external_ram_select, code_rd_en, par_cfg_wr_en, xram_wr_en, eram_wr_en;
  logic         code_rd_valid_q, code_rd_blocked_q, arr_rd_en, arr_rd_extra_row, arr_prog_req_q;
  logic         arr_prog_extra_row_q, arr_buf_written_q, arr_done, double_speed_select_q, boot_region_map_q;
  logic [7:0]   sfr_addr, sfr_wdata, xdata_wdata, par_cfg_wdata, sfr_rdata_q, code_rdata_q;
  logic [7:0]   arr_rd_data, arr_buf_data_q, cfg, d, ldd;
  logic [15:0]  xdata_addr, code_addr, arr_rd_addr, reset_vector_q, a;
  logic [8:0]   arr_prog_page_q;
  logic [6:0]   arr_buf_addr, pa, ldi;
  logic [3:0]   clocks_per_cycle_q;
  logic [2:0]   general_lock_bits;
  logic [31:0]  seed;
  ufac_region_t region;
  int           n_fail, comparisons, cyc;

  ufac_ctrl ufac_ctrl_i (.clk, .rst_n, .por_n, .exec_region(region), .sfr_wr_en, .sfr_rd_en,
    .sfr_addr, .sfr_wdata, .sfr_rdata_q, .xdata_wr_en, .xdata_addr, .xdata_wdata,
    .external_ram_select, .xram_wr_en, .eram_wr_en, .code_rd_en, .code_addr, .code_rdata_q,
    .code_rd_valid_q, .code_rd_blocked_q, .arr_rd_en, .arr_rd_extra_row, .arr_rd_addr, .arr_rd_data,
    .arr_prog_req_q, .arr_prog_extra_row_q, .arr_prog_page_q, .arr_buf_addr, .arr_buf_data_q,
    .arr_buf_written_q, .arr_done, .par_cfg_wr_en, .par_cfg_wdata, .double_speed_select_q,
    .clocks_per_cycle_q, .boot_region_map_q, .reset_vector_q, .general_lock_bits);
  ufac_array_model ufac_array_model_i (.clk, .rst_n, .slow, .arr_rd_en, .arr_rd_extra_row,
    .arr_rd_addr, .arr_rd_data, .arr_prog_req_q, .arr_buf_addr, .arr_done);

  always #12.5 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [7:0] arr_exp(input logic [15:0] ad, input logic x);
    return ad[7:0] ^ ad[15:8] ^ (x ? 8'h5a : 8'h00);
  endfunction : arr_exp

  task automatic finish_test;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic sfr(input logic w, input logic [7:0] ad, input logic [7:0] wd);
    @(posedge clk);
    sfr_wr_en <= w;
    sfr_rd_en <= !w;
    sfr_addr <= ad;
    sfr_wdata <= wd;
    @(posedge clk);
    sfr_wr_en <= 1'b0;
    sfr_rd_en <= 1'b0;
    #1 d = sfr_rdata_q;
  endtask : sfr

  task automatic wr(input logic [7:0] v);
    sfr(1'b1, FCTL_ADDR, v);
  endtask : wr

  task automatic rdc(input logic [7:0] e);
    sfr(1'b0, FCTL_ADDR, 8'h00);
    chk(16'(d), 16'(e));
  endtask : rdc

  task automatic launch(input logic [3:0] lo);
    wr({KEY_ARM, lo});
    wr({KEY_FIRE, lo});
  endtask : launch

  task automatic xwr(input logic [15:0] ad, input logic [7:0] v, input logic map);
    @(posedge clk);
    xdata_wr_en <= 1'b1;
    xdata_addr <= ad;
    xdata_wdata <= v;
    ldi = ad[6:0];
    ldd = v;
    #1;
    chk(16'(xram_wr_en), 16'(!map && external_ram_select));
    chk(16'(eram_wr_en), 16'(!map && !external_ram_select));
    @(posedge clk);
    xdata_wr_en <= 1'b0;
  endtask : xwr

  task automatic crd(input logic [15:0] ad, input logic [7:0] e, input logic eb);
    @(posedge clk);
    code_rd_en <= 1'b1;
    code_addr <= ad;
    @(posedge clk);
    code_rd_en <= 1'b0;
    #1;
    chk(16'(code_rd_valid_q), 16'h0001);
    chk(16'(code_rdata_q), 16'(e));
    chk(16'(code_rd_blocked_q), 16'(eb));
  endtask : crd

  task automatic idle;
    for (int i = 0; i < 40 && arr_prog_req_q === 1'b1; i++) @(posedge clk);
    #1 chk(16'(arr_prog_req_q), 16'h0000);
  endtask : idle

  task automatic par(input logic [7:0] v);
    @(posedge clk);
    par_cfg_wr_en <= 1'b1;
    par_cfg_wdata <= v;
    @(posedge clk);
    par_cfg_wr_en <= 1'b0;
    cfg = v;
  endtask : par

  task automatic do_rst(input int n);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (n) @(posedge clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    #1;
    chk(16'(double_speed_select_q), 16'(!cfg[CFG_SPEED_BIT]));
    chk(16'(clocks_per_cycle_q), cfg[CFG_SPEED_BIT] ? 16'h000c : 16'h0006);
    chk(16'(boot_region_map_q), 16'(!cfg[CFG_JUMP_BIT]));
    chk(reset_vector_q, cfg[CFG_JUMP_BIT] ? VEC_USER : VEC_BOOT);
    chk(16'(general_lock_bits), 16'(cfg[2:0]));
    rdc(FCTL_RESET);
  endtask : do_rst

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end

  // The staged copy answers one cycle after the array asks, so the address is delayed to match.
  always @(posedge clk) begin
    pa <= arr_buf_addr;
    if (arr_prog_req_q === 1'b1 && pa == ldi) begin
      chk(16'(arr_buf_written_q), 16'h0001);
      chk(16'(arr_buf_data_q), 16'(ldd));
    end
  end

  initial begin
    {clk, slow, sfr_wr_en, sfr_rd_en, xdata_wr_en, external_ram_select} = '0;
    {code_rd_en, par_cfg_wr_en, rst_n, por_n, n_fail, comparisons, cyc} = '0;
    {sfr_addr, sfr_wdata, xdata_wdata, par_cfg_wdata, xdata_addr, code_addr} = '0;
    region = REGION_USER;
    seed = 32'ha9fe;
    cfg = CFG_ERASED;
    repeat (6) @(posedge clk);
    do_rst(1);
    sfr(1'b0, 8'hd3, 8'h00);
    chk(16'(d), 16'h0000);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      external_ram_select <= i[0];
      wr({4'h0, i[1], 3'h0});
      rdc({4'h0, i[1], 3'h0});
      xwr(seed[15:0], seed[23:16], i[1]);
    end
    $display("test routing done");
    for (int i = 0; i < 4; i++) begin
      region <= (i == 0) ? REGION_USER : (i == 1) ? REGION_EXT : REGION_BOOT;
      if (i < 2) begin
        launch(4'h0);
      end else if (i == 2) begin
        wr(8'ha0);
        wr(8'h50);
      end else begin
        wr(8'h50);
        wr(8'h30);
        wr(8'ha0);
      end
      repeat (2) @(posedge clk);
      #1 chk(16'(arr_prog_req_q), 16'h0000);
      rdc((i == 2) ? 8'h50 : 8'ha0);
    end
    wr(8'h01);
    rdc(8'h00);
    $display("test refused launch done");
    for (int m = 0; m < 2; m++) begin
      seed = lfsr(seed);
      slow <= m[0];
      wr(8'h08);
      xwr({seed[15:7], 7'h02}, seed[23:16], 1'b1);
      launch({2'b10, m[0], 1'b0});
      chk(16'(arr_prog_req_q), 16'h0001);
      chk(16'(arr_prog_extra_row_q), 16'(m[0]));
      chk(16'(arr_prog_page_q), 16'(seed[15:7]));
      rdc({KEY_FIRE, 2'b10, m[0], 1'b1});
      idle();
      rdc({KEY_FIRE, 2'b10, m[0], 1'b0});
    end
    $display("test programming done");
    seed = lfsr(seed);
    xwr({seed[8:0], 7'h00}, seed[23:16], 1'b1);
    launch(4'b1100);
    repeat (4) @(posedge clk);
    cfg = {seed[23:20], cfg[3:0]};
    wr(8'h04);
    crd(CFG_CODE_ADDR, cfg, 1'b0);
    crd(16'h0001, READ_BLANK, 1'b0);
    wr(8'h08);
    xwr(16'h0000, ~cfg, 1'b1);
    launch(4'b1110);
    chk(16'(arr_prog_req_q), 16'h0000);
    launch(4'b1100);
    repeat (4) @(posedge clk);
    wr(8'h04);
    crd(CFG_CODE_ADDR, cfg, 1'b0);
    $display("test configuration done");
    region <= REGION_USER;
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      a = i[0] ? {9'h1ff, seed[6:0]} : {1'b0, seed[14:0]};
      wr({6'h00, i[1], 1'b0});
      crd(a, i[1] ? (i[0] ? arr_exp(a, 1'b1) : READ_BLANK) : arr_exp(a, 1'b0), 1'b0);
    end
    $display("test code reads done");
    par(8'h38);
    do_rst(2);
    crd(16'hf900, READ_BLANK, 1'b1);
    region <= REGION_BOOT;
    crd(16'hf900, arr_exp(16'hf900, 1'b0), 1'b0);
    region <= REGION_EXT;
    crd(16'h0100, READ_BLANK, 1'b1);
    wr(8'h08);
    xwr(16'h0000, 8'h00, 1'b1);
    region <= REGION_BOOT;
    launch(4'b1100);
    repeat (4) @(posedge clk);
    wr(8'h04);
    crd(CFG_CODE_ADDR, cfg, 1'b0);
    par(CFG_ERASED);
    do_rst(2);
    region <= REGION_EXT;
    crd(16'h0100, arr_exp(16'h0100, 1'b0), 1'b0);
    $display("test boot and locks done");
    finish_test();
  end
endmodule : tb
`default_nettype wire
